// >>> logic/atrr_pkg.sv
package atrr_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_CNT = 5'h10;

  // Byte addresses within a page
  localparam logic [6:0] ADDR_PAGE_SEL = 7'h00;
  localparam logic [6:0] ADDR_Y_THR = 7'h30;
  localparam logic [6:0] ADDR_Z_THR = 7'h32;
  localparam logic [6:0] ADDR_P_THR = 7'h3A;
  localparam logic [6:0] ADDR_FW_REV = 7'h78;
  localparam logic [6:0] ADDR_FAC_DM = 7'h7A;
  localparam logic [6:0] ADDR_FAC_YR = 7'h7C;

  localparam logic [15:0] PAGE_ALARM = 16'h0003;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Alarm configuration and status bit positions
  localparam int CFG2_Y_EN = 3;
  localparam int CFG2_Y_DYN = 0;
  localparam int CFG2_Y_GT = 1;
  localparam int CFG2_Z_EN = 7;
  localparam int CFG2_Z_DYN = 4;
  localparam int CFG2_Z_GT = 5;
  localparam int CFG3_P_EN = 7;
  localparam int CFG3_P_GT = 5;
  localparam int CFG3_P_DYN = 4;
  localparam int STS_Y = 4;
  localparam int STS_Z = 5;
  localparam int STS_P = 11;

  // Pin vector order for the synchroniser
  localparam int PIN_MOSI = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SCLK = 2;
  localparam logic [2:0] PIN_IDLE = 3'h6;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } atrr_cmd_t;

  typedef struct packed {
    logic en;
    logic dyn;
    logic gt;
  } atrr_alarm_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_EXEC = 3'b100
  } atrr_state_t;

endpackage

// >>> logic/atrr_pin_sync.sv
`timescale 1ns/10ps
module atrr_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] IDLE_LVL = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  import atrr_pkg::*;

  if (W < 1)
  begin : g_bad_w
    $error("synchroniser width must be at least one");
  end

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic [W-1:0] lvl_d, rise_d, fall_d;

  // A change counts only once the second and third stages agree
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_comb
    begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      rise_d[i] = lvl_d[i] & ~lvl_q[i];
      fall_d[i] = ~lvl_d[i] & lvl_q[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      s1_q <= IDLE_LVL;
      s2_q <= IDLE_LVL;
      s3_q <= IDLE_LVL;
      lvl_q <= IDLE_LVL;
      rise_q <= '0;
      fall_q <= '0;
    end
    else if (ce_i)
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign lvl_o = lvl_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule

// >>> logic/atrr_alarm_cmp.sv
`timescale 1ns/10ps
module atrr_alarm_cmp (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input atrr_pkg::atrr_alarm_ctl_t ctl_i,
  input wire logic [15:0] thr_i,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  output logic alarm_o
);
  import atrr_pkg::*;

  logic [15:0] prev_q, prev_d, value;
  logic has_prev_q, has_prev_d, alarm_q, alarm_d, hit;

  always_comb
  begin
    // Delta wraps at 16 bits, as the sample word does
    value = ctl_i.dyn ? 16'(sample_i - prev_q) : sample_i;
    hit = ctl_i.gt ? ($signed(value) > $signed(thr_i))
                   : ($signed(value) < $signed(thr_i));
    // No delta exists before the first sample
    if (ctl_i.dyn && !has_prev_q)
      hit = 1'b0;
    prev_d = prev_q;
    has_prev_d = has_prev_q;
    alarm_d = alarm_q & ctl_i.en;
    if (sample_valid_i)
    begin
      prev_d = sample_i;
      has_prev_d = 1'b1;
      alarm_d = ctl_i.en & hit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      prev_q <= REG_RESET;
      has_prev_q <= 1'b0;
      alarm_q <= 1'b0;
    end
    else if (ce_i)
    begin
      prev_q <= prev_d;
      has_prev_q <= has_prev_d;
      alarm_q <= alarm_d;
    end
  end

  assign alarm_o = alarm_q;

endmodule

// >>> logic/atrr_regs.sv
`timescale 1ns/10ps
// Operation
// [RL1] Y accel threshold, 16-bit signed, resets zero
// [RL2] Y threshold active when config2 bit 3
// [RL3] Z accel threshold, 16-bit signed, resets zero
// [RL4] Z threshold active when config2 bit 7
// [RL5] Pressure threshold, 16-bit signed, resets zero
// [RL6] Pressure threshold active when config3 bit 7
// [RL7] Firmware revision read-only, four BCD digits
// [RL8] Each revision nibble holds one decimal digit
// [RL9] Month and day BCD, read-only, limited tens
// [RL10] Year BCD read-only, tens digit limited
// [RL11] Page select reads page, resets zero
// [RL12] Host writes page number to redirect accesses
// [RL13] Config3 bit 5 selects pressure polarity
// [RL14] Config3 bit 4 selects sample-to-sample change
// [RL15] Frame: write flag, byte address, data byte
// [RL16] Writes to read-only registers are ignored
// [RL17] Thresholds read back last written value
module atrr_regs #(
  parameter logic [15:0] FW_REV = 16'h0100,
  parameter logic [15:0] FAC_DM = 16'h0101,
  parameter logic [15:0] FAC_YR = 16'h2000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic [15:0] alarm_config_second_i,
  input wire logic [15:0] alarm_config_third_i,
  input wire logic [15:0] y_accel_i,
  input wire logic [15:0] z_accel_i,
  input wire logic [15:0] pressure_i,
  input wire logic sample_valid_i,
  output logic [15:0] page_select_o,
  output logic [15:0] alarm_status_flags_o
);
  import atrr_pkg::*;

  function automatic logic bcd_ok(input logic [15:0] v, input logic [3:0] hi_max,
                                  input logic [3:0] tens_max);
    bcd_ok = (v[15:12] <= hi_max) && (v[11:8] <= 4'h9) && (v[7:4] <= tens_max)
             && (v[3:0] <= 4'h9);
  endfunction

  // Fixed factory words must be legal BCD
  if (!bcd_ok(FW_REV, 4'h9, 4'h9)) // RL8
  begin : g_bad_rev
    $error("firmware revision parameter is not BCD");
  end
  if (!bcd_ok(FAC_DM, 4'h2, 4'h3)) // RL9
  begin : g_bad_dm
    $error("factory month and day parameter is not BCD");
  end
  if (!bcd_ok(FAC_YR, 4'h9, 4'h3)) // RL10
  begin : g_bad_yr
    $error("factory year parameter is not BCD");
  end

  logic [2:0] pin_lvl, pin_rise, pin_fall;
  logic sclk_rise, sclk_fall, cs_start, cs_end, mosi_lvl;

  atrr_pin_sync #(.W(3), .IDLE_LVL(PIN_IDLE)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .pin_i({sclk_i, cs_n_i, mosi_i}),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign sclk_rise = pin_rise[PIN_SCLK];
  assign sclk_fall = pin_fall[PIN_SCLK];
  assign cs_start = pin_fall[PIN_CS];
  assign cs_end = pin_rise[PIN_CS];
  assign mosi_lvl = pin_lvl[PIN_MOSI];

  atrr_state_t state_q, state_d;
  logic [15:0] rx_q, rx_d, tx_q, tx_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [6:0] rd_addr_q, rd_addr_d;
  logic [15:0] page_q, page_d, ythr_q, ythr_d, zthr_q, zthr_d, pthr_q, pthr_d;
  logic miso_q, miso_d, oe_n_q, oe_n_d;
  atrr_cmd_t cmd;
  logic [15:0] rd_word;

  assign cmd = atrr_cmd_t'(rx_q);

  // Registers are 16 bits over two byte addresses, low byte even
  function automatic logic [15:0] read_word(input logic [6:0] a, input logic [15:0] pg,
                                            input logic [15:0] y, input logic [15:0] z,
                                            input logic [15:0] p);
    logic [6:0] w;
    w = {a[6:1], 1'b0};
    read_word = READ_ZERO;
    if (w == ADDR_PAGE_SEL)
      read_word = pg; // RL11
    else if (pg == PAGE_ALARM)
    begin
      unique case (w)
        ADDR_Y_THR: read_word = y; // RL17
        ADDR_Z_THR: read_word = z; // RL17
        ADDR_P_THR: read_word = p; // RL17
        ADDR_FW_REV: read_word = FW_REV; // RL7
        ADDR_FAC_DM: read_word = FAC_DM; // RL9
        ADDR_FAC_YR: read_word = FAC_YR; // RL10
        default: read_word = READ_ZERO;
      endcase
    end
  endfunction

  assign rd_word = read_word(rd_addr_q, page_q, ythr_q, zthr_q, pthr_q);

  always_comb
  begin
    state_d = state_q;
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    rd_addr_d = rd_addr_q;
    page_d = page_q;
    ythr_d = ythr_q;
    zthr_d = zthr_q;
    pthr_d = pthr_q;
    miso_d = miso_q;
    oe_n_d = oe_n_q;
    unique case (state_q)
      ST_IDLE:
      begin
        // Answer to the previous read goes out in this frame
        if (cs_start)
        begin
          state_d = ST_SHIFT;
          cnt_d = '0;
          tx_d = rd_word;
          miso_d = rd_word[FRAME_BITS-1];
          oe_n_d = 1'b0;
        end
      end
      ST_SHIFT:
      begin
        if (sclk_rise && cnt_q != FRAME_CNT)
        begin
          rx_d = {rx_q[FRAME_BITS-2:0], mosi_lvl}; // RL15
          cnt_d = CNT_W'(cnt_q + 1'b1);
        end
        if (sclk_fall && cnt_q != '0)
        begin
          tx_d = {tx_q[FRAME_BITS-2:0], 1'b0};
          miso_d = tx_q[FRAME_BITS-2];
        end
        if (cs_end)
        begin
          oe_n_d = 1'b1;
          // Short frames are dropped whole
          state_d = (cnt_q == FRAME_CNT) ? ST_EXEC : ST_IDLE; // RL15
        end
      end
      ST_EXEC:
      begin
        state_d = ST_IDLE;
        if (!cmd.wr)
          rd_addr_d = cmd.addr; // RL15
        else if ({cmd.addr[6:1], 1'b0} == ADDR_PAGE_SEL)
        begin
          // Page select lives at the bottom of every page
          if (cmd.addr[0])
            page_d[15:8] = cmd.data; // RL12
          else
            page_d[7:0] = cmd.data; // RL12
        end
        else if (page_q == PAGE_ALARM)
        begin
          // Read-only words fall through untouched
          unique case ({cmd.addr[6:1], 1'b0}) // RL16
            ADDR_Y_THR:
              if (cmd.addr[0]) ythr_d[15:8] = cmd.data; else ythr_d[7:0] = cmd.data; // RL1
            ADDR_Z_THR:
              if (cmd.addr[0]) zthr_d[15:8] = cmd.data; else zthr_d[7:0] = cmd.data; // RL3
            ADDR_P_THR:
              if (cmd.addr[0]) pthr_d[15:8] = cmd.data; else pthr_d[7:0] = cmd.data; // RL5
            default:
            begin
            end
          endcase
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_IDLE;
      rx_q <= REG_RESET;
      tx_q <= REG_RESET;
      cnt_q <= '0;
      rd_addr_q <= ADDR_PAGE_SEL;
      page_q <= REG_RESET; // RL11
      ythr_q <= REG_RESET; // RL1
      zthr_q <= REG_RESET; // RL3
      pthr_q <= REG_RESET; // RL5
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      rd_addr_q <= rd_addr_d;
      page_q <= page_d;
      ythr_q <= ythr_d;
      zthr_q <= zthr_d;
      pthr_q <= pthr_d;
      miso_q <= miso_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign miso_o = miso_q;
  assign miso_oe_n_o = oe_n_q;
  assign page_select_o = page_q;

  atrr_alarm_ctl_t y_ctl, z_ctl, p_ctl;
  logic y_alarm, z_alarm, p_alarm;

  assign y_ctl = '{en: alarm_config_second_i[CFG2_Y_EN], dyn: alarm_config_second_i[CFG2_Y_DYN],
                   gt: alarm_config_second_i[CFG2_Y_GT]}; // RL2
  assign z_ctl = '{en: alarm_config_second_i[CFG2_Z_EN], dyn: alarm_config_second_i[CFG2_Z_DYN],
                   gt: alarm_config_second_i[CFG2_Z_GT]}; // RL4
  assign p_ctl = '{en: alarm_config_third_i[CFG3_P_EN], dyn: alarm_config_third_i[CFG3_P_DYN],
                   gt: alarm_config_third_i[CFG3_P_GT]}; // RL6 RL13 RL14

  atrr_alarm_cmp u_y_cmp (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .ctl_i(y_ctl),
    .thr_i(ythr_q),
    .sample_i(y_accel_i),
    .sample_valid_i(sample_valid_i),
    .alarm_o(y_alarm)
  );

  atrr_alarm_cmp u_z_cmp (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .ctl_i(z_ctl),
    .thr_i(zthr_q),
    .sample_i(z_accel_i),
    .sample_valid_i(sample_valid_i),
    .alarm_o(z_alarm)
  );

  atrr_alarm_cmp u_p_cmp (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .ctl_i(p_ctl),
    .thr_i(pthr_q),
    .sample_i(pressure_i),
    .sample_valid_i(sample_valid_i),
    .alarm_o(p_alarm)
  );

  always_comb
  begin
    alarm_status_flags_o = READ_ZERO;
    alarm_status_flags_o[STS_Y] = y_alarm; // RL2
    alarm_status_flags_o[STS_Z] = z_alarm; // RL4
    alarm_status_flags_o[STS_P] = p_alarm; // RL6
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_thr_reset: // RL1
    assert property ($rose(reset_n_i) |-> ythr_q == REG_RESET && zthr_q == REG_RESET
                     && pthr_q == REG_RESET && page_q == REG_RESET)
      else $error("registers not zero after reset");
  a_y_write: // RL17
    assert property (ce_i && state_q == ST_EXEC && cmd.wr && page_q == PAGE_ALARM
                     && cmd.addr == ADDR_Y_THR |=> ythr_q[7:0] == $past(rx_q[7:0]))
      else $error("y threshold low byte not stored");
  a_p_write_hi: // RL5
    assert property (ce_i && state_q == ST_EXEC && cmd.wr && page_q == PAGE_ALARM
                     && cmd.addr == (ADDR_P_THR | 7'h01)
                     |=> pthr_q[15:8] == $past(rx_q[7:0]) && $stable(pthr_q[7:0]))
      else $error("pressure threshold high byte not stored");
  a_ro_ignored: // RL16
    assert property (ce_i && state_q == ST_EXEC && cmd.wr && cmd.addr[6:1] == ADDR_FW_REV[6:1]
                     |=> $stable(ythr_q) && $stable(zthr_q) && $stable(pthr_q) && $stable(page_q))
      else $error("write to read-only word changed state");
  a_page_write: // RL12
    assert property (ce_i && state_q == ST_EXEC && cmd.wr && cmd.addr == ADDR_PAGE_SEL
                     |=> page_select_o[7:0] == $past(rx_q[7:0]))
      else $error("page select not updated");
  a_read_load: // RL7
    assert property (ce_i && state_q == ST_IDLE && cs_start
                     |=> tx_q == $past(rd_word) && miso_o == $past(rd_word[15]) && !miso_oe_n_o)
      else $error("read word not loaded at frame start");
  a_short_frame: // RL15
    assert property (ce_i && state_q == ST_SHIFT && cs_end && cnt_q != FRAME_CNT
                     |=> state_q == ST_IDLE ##1 state_q != ST_EXEC)
      else $error("short frame executed");
  a_y_off: // RL2
    assert property (ce_i && !alarm_config_second_i[CFG2_Y_EN] |=> !alarm_status_flags_o[STS_Y])
      else $error("y alarm set while disabled");
  a_z_off: // RL4
    assert property (ce_i && !alarm_config_second_i[CFG2_Z_EN] |=> !alarm_status_flags_o[STS_Z])
      else $error("z alarm set while disabled");
  a_p_static: // RL13
    assert property (ce_i && sample_valid_i && alarm_config_third_i[CFG3_P_EN]
                     && !alarm_config_third_i[CFG3_P_DYN] && alarm_config_third_i[CFG3_P_GT]
                     |=> alarm_status_flags_o[STS_P]
                         == ($signed($past(pressure_i)) > $signed($past(pthr_q))))
      else $error("pressure alarm result wrong");
  a_idle_release:
    assert property (state_q == ST_IDLE && !cs_start |=> miso_oe_n_o)
      else $error("data pin driven outside a frame");

  c_write: cover property (state_q == ST_EXEC && cmd.wr && page_q == PAGE_ALARM);
  c_read: cover property (state_q == ST_EXEC && !cmd.wr ##[1:200] cs_start);
  c_p_alarm: cover property (alarm_status_flags_o[STS_P]);

endmodule

// >>> bench/atrr_host_model.sv
`timescale 1ns/10ps
module atrr_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_n_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  logic last_q = 1'b0;
  logic line;
  always @(posedge clk_i)
  begin
    if (!miso_oe_n_i)
      last_q <= miso_i;
  end
  // Released line shows the inverse of its last level, so stale data never passes
  assign line = miso_oe_n_i ? ~last_q : miso_i;
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  // Mode 3 frame: clock idles high, data out on fall; each read bit is taken at the end
  // of the high phase, since the device shows it about five clocks after the fall
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    rx = '0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      sclk_o <= 1'b0;
      mosi_o <= tx[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      rx = {rx[14:0], line};
    end
    cs_n_o <= 1'b1;
    mosi_o <= ~tx[0];
    // Gap covers synchroniser and execute latency before the next frame
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import atrr_pkg::*;
  // Arbitrary BCD contents, distinct from the design defaults
  localparam logic [15:0] FW = 16'h0347;
  localparam logic [15:0] DM = 16'h0915;
  localparam logic [15:0] YR = 16'h2019;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic [15:0] cfg2 = '0;
  logic [15:0] cfg3 = '0;
  logic [15:0] ya = '0;
  logic [15:0] za = '0;
  logic [15:0] pa = '0;
  logic valid = 1'b0;
  logic [15:0] page;
  logic [15:0] sts;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  atrr_regs #(.FW_REV(FW), .FAC_DM(DM), .FAC_YR(YR)) uut (
    .clk_i(clk),
    .reset_n_i(reset_n),
    .ce_i(ce),
    .sclk_i(sclk),
    .cs_n_i(cs_n),
    .mosi_i(mosi),
    .miso_o(miso),
    .miso_oe_n_o(miso_oe_n),
    .alarm_config_second_i(cfg2),
    .alarm_config_third_i(cfg3),
    .y_accel_i(ya),
    .z_accel_i(za),
    .pressure_i(pa),
    .sample_valid_i(valid),
    .page_select_o(page),
    .alarm_status_flags_o(sts)
  );

  atrr_host_model host (
    .clk_i(clk),
    .miso_i(miso),
    .miso_oe_n_i(miso_oe_n),
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .mosi_o(mosi)
  );

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] rx;
    host.frame({1'b1, a, d}, rx);
  endtask

  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr8({a[6:1], 1'b0}, v[7:0]);
    wr8({a[6:1], 1'b1}, v[15:8]);
  endtask

  // Read answer arrives in the frame after the one carrying the address
  task automatic rd16(input string what, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] rx;
    host.frame({1'b0, a, 8'h00}, rx);
    host.frame(16'h0000, rx);
    check(what, exp, rx);
  endtask

  task automatic alarm(input logic [15:0] c2, c3, y, z, p, exp);
    @(posedge clk);
    cfg2 <= c2;
    cfg3 <= c3;
    ya <= y;
    za <= z;
    pa <= p;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    repeat (2) @(posedge clk);
    check("alarm_status", exp, sts);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("[FAIL] timeout expected finish seen hang");
      end_of_test();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("page_reset", 16'h0000, page);
    check("status_reset", 16'h0000, sts);
    check("oe_reset", 16'h0001, {15'h0000, miso_oe_n});
    wr8(ADDR_Y_THR, 8'h55);
    wr8(ADDR_PAGE_SEL, 8'h03);
    check("page_sel", 16'h0003, page);
    rd16("page_read", ADDR_PAGE_SEL, 16'h0003);
    rd16("y_thr_reset", ADDR_Y_THR, 16'h0000);
    rd16("z_thr_reset", ADDR_Z_THR, 16'h0000);
    rd16("p_thr_reset", ADDR_P_THR, 16'h0000);
    wr16(ADDR_Y_THR, 16'h0100);
    wr16(ADDR_Z_THR, 16'hFF80);
    wr16(ADDR_P_THR, 16'h0100);
    rd16("y_thr", ADDR_Y_THR, 16'h0100);
    rd16("z_thr", ADDR_Z_THR, 16'hFF80);
    rd16("p_thr", ADDR_P_THR, 16'h0100);
    rd16("fw_rev", ADDR_FW_REV, FW);
    rd16("fac_dm", ADDR_FAC_DM, DM);
    rd16("fac_yr", ADDR_FAC_YR, YR);
    wr16(ADDR_FW_REV, 16'hFFFF);
    wr16(ADDR_FAC_DM, 16'hFFFF);
    wr16(ADDR_FAC_YR, 16'hFFFF);
    rd16("fw_rev_ro", ADDR_FW_REV, FW);
    rd16("fac_dm_ro", ADDR_FAC_DM, DM);
    rd16("fac_yr_ro", ADDR_FAC_YR, YR);
    rd16("unmapped", 7'h40, 16'h0000);
    // Threshold writes on another page must not land
    wr8(ADDR_PAGE_SEL, 8'h02);
    check("page_two", 16'h0002, page);
    wr16(ADDR_Y_THR, 16'h7777);
    wr8(ADDR_PAGE_SEL, 8'h03);
    rd16("y_thr_kept", ADDR_Y_THR, 16'h0100);
    alarm(16'h000A, 16'h0000, 16'h0200, 16'h0000, 16'h0000, 16'h0010);
    alarm(16'h000A, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
    alarm(16'h0080, 16'h0000, 16'h0200, 16'hFF00, 16'h0000, 16'h0020);
    alarm(16'h0000, 16'h0000, 16'h0200, 16'hFF00, 16'h0000, 16'h0000);
    alarm(16'h0000, 16'h00A0, 16'h0000, 16'h0000, 16'h0200, 16'h0800);
    alarm(16'h0000, 16'h0080, 16'h0000, 16'h0000, 16'h0200, 16'h0000);
    alarm(16'h0000, 16'h0080, 16'h0000, 16'h0000, 16'h0050, 16'h0800);
    alarm(16'h0000, 16'h00B0, 16'h0000, 16'h0000, 16'h0300, 16'h0800);
    alarm(16'h0000, 16'h00B0, 16'h0000, 16'h0000, 16'h0350, 16'h0000);
    alarm(16'h0000, 16'h0020, 16'h0000, 16'h0000, 16'h0350, 16'h0000);
    // Y and Z dynamic greater-than modes, second sample chosen so static and delta results differ
    alarm(16'h00BB, 16'h0000, 16'h0300, 16'hFE00, 16'h0000, 16'h0010);
    alarm(16'h00BB, 16'h0000, 16'h0350, 16'hFF00, 16'h0000, 16'h0020);
    // Clock enable low must freeze the flags through a sample pulse
    ce <= 1'b0;
    alarm(16'h00BB, 16'h0000, 16'h0350, 16'hFE00, 16'h0000, 16'h0020);
    ce <= 1'b1;
    // Reset in mid-run clears thresholds, page and flags
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("status_rst2", 16'h0000, sts);
    check("page_rst2", 16'h0000, page);
    wr8(ADDR_PAGE_SEL, 8'h03);
    rd16("y_thr_rst2", ADDR_Y_THR, 16'h0000);
    end_of_test();
  end
endmodule
